// ---- pkg/port_mode_pkg.sv ----
// Constants, field layouts and carrier types of the port mode and counter block.
package port_mode_pkg;
    // Ancillary function opcodes, low byte of the first control-block word.
    localparam logic [7:0] OP_READ_MODE = 8'h0E;
    localparam logic [7:0] OP_WRITE_MODE = 8'h0F;
    // Mode word bit positions.
    localparam int ACCEPT_ALL_DESTINATIONS = 15;
    localparam int ACCEPT_ALL_MULTICAST = 14;
    localparam int NO_RECEIVE_CHAINING = 13;
    localparam int SHORT_FRAME_ZERO_FILL = 12;
    localparam int COLLISION_TEST_IRQ_ENABLE = 11;
    localparam int MAINT_MESSAGE_SUPPRESS = 9;
    localparam int INTERNAL_SELECT = 6;
    localparam int CRC_GENERATION_OFF = 3;
    localparam int LOOP_ENABLE = 2;
    // Bits that must be zero in a written mode word, and the ignored bit 0.
    localparam logic [15:0] ZERO_REQUIRED_FIELD = 16'h05B2;
    localparam logic [15:0] MODE_IGNORED = 16'h0001;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // Frame size figures in bytes.
    localparam logic [10:0] MIN_DATA_BYTES = 11'h006;
    localparam logic [7:0] LOOP_BYTES_CRC = 8'h20;
    localparam logic [7:0] LOOP_BYTES_NOCRC = 8'h24;
    localparam logic [7:0] SILO_BYTES = 8'h40;
    // Babble timer: longest legal transmitter on-time.
    localparam int CLK_MHZ = 40;
    localparam int MAX_FRAME_US = 1230;
    localparam int MAX_FRAME_CYCLES = MAX_FRAME_US * CLK_MHZ;
    localparam int TIMER_W = 16;
    localparam int COUNT_W = 16;

    // Function sequencer, Gray coded along idle, busy, done.
    typedef enum logic [1:0] {
        FN_IDLE = 2'b00,
        FN_BUSY = 2'b01,
        FN_DONE = 2'b11
    } fn_state_t;

    // Loopback selection decoded from loop enable and internal select.
    typedef enum logic [1:0] {
        LOOP_NONE = 2'b00,
        LOOP_EXTERNAL = 2'b01,
        LOOP_INTERNAL = 2'b10
    } loop_mode_t;

    // One ancillary function request from the host driver.
    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] data;
    } func_req_t;

    // State of the counter module.
    typedef struct packed {
        logic [COUNT_W-1:0] count;
    } cnt_state_t;

    // State of the main block.
    typedef struct packed {
        fn_state_t fn;
        func_req_t req;
        logic [15:0] mode;
        logic [15:0] rdata;
        logic err;
        logic [TIMER_W-1:0] timer;
        logic txStop;
        logic babbleEv;
        logic driverErrEv;
        logic rxAccept;
        logic rxTruncate;
        logic [2:0] padBytes;
        logic cerrSeen;
        logic irq;
    } mode_state_t;
endpackage : port_mode_pkg

// ---- src/event_counter.sv ----
// Sixteen-bit event counter that sticks at its top value.
`timescale 1ns/1ps
module event_counter
    import port_mode_pkg::*;
(
    input wire logic mclk, // Adapter clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic eventIn, // One-cycle event pulse.
    output logic [COUNT_W-1:0] count // Running count.
);
    cnt_state_t cur;
    cnt_state_t next_cur;

    // Saturating so that a long-running fault still reads as many, not few.
    always_comb begin
        next_cur = cur;
        if (eventIn && cur.count != {COUNT_W{1'b1}}) begin
            next_cur.count = cur.count + 16'h0001;
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign count = cur.count;

    count_step_a: assert property (@(posedge mclk) disable iff (!nrst)
        eventIn && count != 16'hFFFF |=> count == $past(count) + 16'h0001)
        else $error("Counter missed an event.");
endmodule : event_counter

// ---- src/port_mode_ctrl.sv ----
// Mode word function, frame acceptance controls and error counters of the port.
`timescale 1ns/1ps
// What this block does
// - Count host functions issued while an earlier one is still in progress.
// - Count each transmission the controller cuts off as too long.
// - Timer stops transmitter held on longer than a maximum frame; counts babble.
// - Opcode 14 reads, 15 writes the mode word; high byte must be zero.
// - Mode bit 15 accepts every frame; cleared at reset.
// - Mode bit 14 accepts every multicast frame; cleared at reset.
// - Mode bit 13 disables receive chaining, truncating oversized frames.
// - Mode bit 12 zero-fills transmit data fields shorter than six bytes.
// - Mode bit 11 raises interrupt when collision-test error becomes set.
// - Mode bit 9 drops maintenance messages and stops periodic identity messages.
// - Mode bit 6 picks internal or external loopback, only with loop enable.
// - Internal loopback is limited to the controller's internal buffer depth.
// - Loop, internal: 00 normal, 01 error, 10 external, 11 internal.
// - Mode bit 3 omits CRC bytes and stops maintenance message handling.
// - Mode bit 2 loops own frames, 32 or 36 bytes, no maintenance.
module port_mode_ctrl
    import port_mode_pkg::*;
#(
    parameter int MAX_TX_CYCLES = MAX_FRAME_CYCLES // Babble limit in clock cycles.
) (
    input wire logic mclk, // Adapter clock, 40 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic funcValid, // Host issues a function this cycle.
    input wire func_req_t funcReq, // Opcode word and mode data word.
    output logic funcDone, // Function finished, one cycle.
    output logic funcError, // Finished function was rejected.
    output logic [15:0] funcRdata, // Mode word returned by a read.
    input wire logic txOn, // Transmitter is sending.
    output logic txStop, // Babble timer forces transmitter off.
    input wire logic rxDecide, // Destination of a received frame is known.
    input wire logic rxAddrMatch, // Destination equals the station address.
    input wire logic rxMulticast, // Destination is multicast.
    output logic rxAccept, // Frame is accepted.
    input wire logic rxOverflow, // Received frame exceeds one buffer.
    output logic rxTruncate, // Truncate instead of chaining.
    input wire logic [10:0] txDataLen, // Data field length of frame to send.
    output logic [2:0] txPadBytes, // Zero bytes to append.
    input wire logic collisionTestError, // Collision-test error status bit.
    output logic collisionIrq, // Interrupt request pulse to host.
    output logic maintSuppress, // Discard maintenance traffic.
    output logic sysIdEnable, // Periodic identity message allowed.
    output logic crcOff, // Send frames without CRC.
    output loop_mode_t loopMode, // Active loopback path.
    output logic [7:0] loopMaxLen, // Longest frame that may be looped.
    output logic [15:0] modeWord, // Current mode word.
    output logic [COUNT_W-1:0] driverErrCount, // Functions issued while busy.
    output logic [COUNT_W-1:0] babbleCount // Babble truncations.
);
    mode_state_t cur;
    mode_state_t next_cur;
    logic [15:0] wr;
    logic loopBits;
    logic badWrite;
    logic [7:0] loopLen;
    logic [1:0] events;
    logic [COUNT_W-1:0] counts [2];

    // Decode of the staged request and the current mode word.
    always_comb begin
        wr = cur.req.data & ~MODE_IGNORED;
        loopBits = cur.mode[LOOP_ENABLE];
        // A write with loop clear but internal set is a command error.
        badWrite = (wr & ZERO_REQUIRED_FIELD) != 16'h0000
            || (!wr[LOOP_ENABLE] && wr[INTERNAL_SELECT]);
        loopLen = cur.mode[CRC_GENERATION_OFF] ? LOOP_BYTES_NOCRC : LOOP_BYTES_CRC;
    end

    // Next-state logic for the function sequencer, timer and frame controls.
    always_comb begin
        next_cur = cur;
        next_cur.babbleEv = 1'b0;
        next_cur.driverErrEv = 1'b0;
        next_cur.irq = 1'b0;
        // A request arriving while one is staged is counted and dropped.
        if (funcValid && cur.fn != FN_IDLE) begin
            next_cur.driverErrEv = 1'b1;
        end
        unique case (cur.fn)
            FN_IDLE: begin
                if (funcValid) begin
                    next_cur.req = funcReq;
                    next_cur.fn = FN_BUSY;
                end
            end
            FN_BUSY: begin
                next_cur.fn = FN_DONE;
                next_cur.err = 1'b1;
                next_cur.rdata = cur.mode;
                if (cur.req.ctl == {8'h00, OP_READ_MODE}) begin
                    next_cur.err = 1'b0;
                end else if (cur.req.ctl == {8'h00, OP_WRITE_MODE} && !badWrite) begin
                    next_cur.err = 1'b0;
                    next_cur.mode = wr;
                    next_cur.rdata = wr;
                end
            end
            FN_DONE: begin
                next_cur.fn = FN_IDLE;
            end
        endcase
        // Babble timer runs only while the transmitter is on.
        if (!txOn) begin
            next_cur.timer = '0;
            next_cur.txStop = 1'b0;
        end else if (!cur.txStop) begin
            next_cur.timer = cur.timer + 16'h0001;
            if (32'(cur.timer) >= MAX_TX_CYCLES - 1) begin
                next_cur.txStop = 1'b1;
                next_cur.babbleEv = 1'b1;
            end
        end
        // Receive acceptance is decided once per frame.
        if (rxDecide) begin
            next_cur.rxAccept = rxAddrMatch || cur.mode[ACCEPT_ALL_DESTINATIONS]
                || (rxMulticast && cur.mode[ACCEPT_ALL_MULTICAST]);
        end
        next_cur.rxTruncate = rxOverflow && cur.mode[NO_RECEIVE_CHAINING];
        next_cur.padBytes = '0;
        if (cur.mode[SHORT_FRAME_ZERO_FILL] && txDataLen < MIN_DATA_BYTES) begin
            next_cur.padBytes = 3'(MIN_DATA_BYTES - txDataLen);
        end
        // Interrupt fires on the rising edge of the collision-test error only.
        next_cur.cerrSeen = collisionTestError;
        next_cur.irq = collisionTestError && !cur.cerrSeen
            && cur.mode[COLLISION_TEST_IRQ_ENABLE];
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cur <= '0;
            cur.mode <= MODE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign events = {cur.babbleEv, cur.driverErrEv};

    // One saturating counter per event source.
    for (genvar i = 0; i < 2; i++) begin : gCnt
        event_counter uCnt (
            .mclk(mclk),
            .nrst(nrst),
            .eventIn(events[i]),
            .count(counts[i])
        );
    end

    assign driverErrCount = counts[0];
    assign babbleCount = counts[1];
    assign funcDone = cur.fn == FN_DONE;
    assign funcError = cur.err;
    assign funcRdata = cur.rdata;
    assign txStop = cur.txStop;
    assign rxAccept = cur.rxAccept;
    assign rxTruncate = cur.rxTruncate;
    assign txPadBytes = cur.padBytes;
    assign collisionIrq = cur.irq;
    assign modeWord = cur.mode;
    assign crcOff = cur.mode[CRC_GENERATION_OFF];
    // Any of these modes takes the maintenance handler off line.
    assign maintSuppress = cur.mode[MAINT_MESSAGE_SUPPRESS]
        || cur.mode[CRC_GENERATION_OFF] || loopBits;
    assign sysIdEnable = !maintSuppress;
    // Internal select is ignored unless loop enable is set.
    assign loopMode = !loopBits ? LOOP_NONE
        : cur.mode[INTERNAL_SELECT] ? LOOP_INTERNAL : LOOP_EXTERNAL;
    // The internal path cannot hold more than the controller buffer.
    assign loopMaxLen = (loopMode == LOOP_INTERNAL && SILO_BYTES < loopLen)
        ? SILO_BYTES : loopLen;

    busy_count_a: assert property (@(posedge mclk) disable iff (!nrst)
        funcValid && cur.fn != FN_IDLE |=> cur.driverErrEv)
        else $error("Busy request was not counted.");
    // The transmitter state that caused the stop is the one seen at the previous edge.
    babble_stop_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(txStop) |-> cur.babbleEv && $past(txOn))
        else $error("Stop without babble event.");
    timer_limit_a: assert property (@(posedge mclk) disable iff (!nrst)
        txOn && !txStop |-> 32'(cur.timer) < MAX_TX_CYCLES)
        else $error("Babble timer ran past limit.");
    done_two_a: assert property (@(posedge mclk) disable iff (!nrst)
        cur.fn == FN_IDLE && funcValid |-> ##2 funcDone)
        else $error("Function not done two cycles after issue.");
    read_keeps_a: assert property (@(posedge mclk) disable iff (!nrst)
        funcDone && !funcError |-> funcRdata == modeWord)
        else $error("Returned mode differs from held mode.");
    promisc_a: assert property (@(posedge mclk) disable iff (!nrst)
        rxDecide && modeWord[ACCEPT_ALL_DESTINATIONS] |=> rxAccept)
        else $error("Frame refused in accept-all mode.");
    multicast_a: assert property (@(posedge mclk) disable iff (!nrst)
        rxDecide && rxMulticast && modeWord[ACCEPT_ALL_MULTICAST] |=> rxAccept)
        else $error("Multicast refused.");
    truncate_a: assert property (@(posedge mclk) disable iff (!nrst)
        rxOverflow && modeWord[NO_RECEIVE_CHAINING] |=> rxTruncate)
        else $error("Oversized frame not truncated.");
    pad_len_a: assert property (@(posedge mclk) disable iff (!nrst)
        modeWord[SHORT_FRAME_ZERO_FILL] && txDataLen == 11'h002 |=> txPadBytes == 3'h4)
        else $error("Wrong pad count.");
    irq_edge_a: assert property (@(posedge mclk) disable iff (!nrst)
        collisionIrq |-> $past(collisionTestError) && !$past(collisionTestError, 2))
        else $error("Interrupt without error edge.");
    maint_a: assert property (@(posedge mclk) disable iff (!nrst)
        modeWord[MAINT_MESSAGE_SUPPRESS] |-> maintSuppress && !sysIdEnable)
        else $error("Maintenance not suppressed.");
    loop_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
        !modeWord[LOOP_ENABLE] |-> loopMode == LOOP_NONE)
        else $error("Loopback without loop enable.");
    loop_err_a: assert property (@(posedge mclk) disable iff (!nrst)
        modeWord[INTERNAL_SELECT] |-> modeWord[LOOP_ENABLE])
        else $error("Illegal loop combination held.");
    loop_len_a: assert property (@(posedge mclk) disable iff (!nrst)
        modeWord[LOOP_ENABLE] && !modeWord[INTERNAL_SELECT] |->
        loopMaxLen == (crcOff ? 8'h24 : 8'h20))
        else $error("Wrong loop length.");

    write_c: cover property (@(posedge mclk) funcDone && !funcError && funcRdata != 16'h0000);
    babble_c: cover property (@(posedge mclk) $rose(txStop));
    busy_c: cover property (@(posedge mclk) cur.driverErrEv);
    irq_c: cover property (@(posedge mclk) collisionIrq);
endmodule : port_mode_ctrl

// ---- test/net_partner.sv ----
// Behavioural model of the transceiver and the remote stations beside the port.
`timescale 1ns/1ps
module net_partner (
    input wire logic mclk, // Adapter clock.
    input wire logic txStop, // Babble cut-off from the port.
    output logic txOn, // Transmitter on.
    output logic rxDecide, // Destination of a frame is known.
    output logic rxAddrMatch, // Own address seen.
    output logic rxMulticast, // Multicast destination seen.
    output logic rxOverflow, // Frame exceeds one buffer.
    output logic [10:0] txDataLen, // Data length of the next frame.
    output logic collisionTestError // Collision-test error status.
);
    // Quiet line at time zero.
    initial begin
        {txOn, rxDecide, rxAddrMatch, rxMulticast, rxOverflow, collisionTestError} = '0;
        txDataLen = 11'h040;
    end

    // One received frame; the address lines are scrambled once released, so stale
    // values cannot pass for real ones.
    task automatic frame(input logic m, input logic mc, input logic ov);
        @(negedge mclk);
        {rxAddrMatch, rxMulticast, rxOverflow, rxDecide} = {m, mc, ov, 1'b1};
        @(negedge mclk);
        {rxAddrMatch, rxMulticast, rxDecide} = {~m, ~mc, 1'b0};
    endtask : frame

    // Keeps the transmitter on until the port cuts it off or n cycles pass.
    task automatic send(input int n, output int stopAt);
        stopAt = -1;
        @(negedge mclk);
        txOn = 1'b1;
        for (int i = 1; i <= n && stopAt < 0; i++) begin
            @(negedge mclk);
            if (txStop === 1'b1) stopAt = i;
        end
        txOn = 1'b0;
    endtask : send

    // Level changes of the slow status lines.
    task automatic setLen(input logic [10:0] v);
        @(negedge mclk);
        txDataLen = v;
    endtask : setLen

    task automatic setCte(input logic v);
        @(negedge mclk);
        collisionTestError = v;
    endtask : setCte
endmodule : net_partner

// ---- test/testbench.sv ----
// Self-checking bench of the port mode word, receive, pad, interrupt and counter logic.
`timescale 1ns/1ps
module testbench;
    import port_mode_pkg::*;
    logic mclk, nrst, funcValid, funcDone, funcError, txOn, txStop, rxDecide, rxAddrMatch;
    logic rxMulticast, rxAccept, rxOverflow, rxTruncate, collisionTestError, collisionIrq;
    logic maintSuppress, sysIdEnable, crcOff;
    logic [15:0] funcRdata, modeWord, driverErrCount, babbleCount;
    logic [10:0] txDataLen;
    logic [2:0] txPadBytes;
    logic [7:0] loopMaxLen;
    loop_mode_t loopMode;
    func_req_t funcReq;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    port_mode_ctrl #(.MAX_TX_CYCLES(20)) DUT (.mclk(mclk), .nrst(nrst), .funcValid(funcValid),
        .funcReq(funcReq), .funcDone(funcDone), .funcError(funcError), .funcRdata(funcRdata),
        .txOn(txOn), .txStop(txStop), .rxDecide(rxDecide), .rxAddrMatch(rxAddrMatch),
        .rxMulticast(rxMulticast), .rxAccept(rxAccept), .rxOverflow(rxOverflow),
        .rxTruncate(rxTruncate), .txDataLen(txDataLen), .txPadBytes(txPadBytes),
        .collisionTestError(collisionTestError), .collisionIrq(collisionIrq),
        .maintSuppress(maintSuppress), .sysIdEnable(sysIdEnable), .crcOff(crcOff),
        .loopMode(loopMode), .loopMaxLen(loopMaxLen), .modeWord(modeWord),
        .driverErrCount(driverErrCount), .babbleCount(babbleCount));

    net_partner far (.mclk(mclk), .txStop(txStop), .txOn(txOn), .rxDecide(rxDecide),
        .rxAddrMatch(rxAddrMatch), .rxMulticast(rxMulticast), .rxOverflow(rxOverflow),
        .txDataLen(txDataLen), .collisionTestError(collisionTestError));

    // Clock at 40 MHz.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // A hang is cut short well beyond the expected run of a few hundred cycles.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One function; the request is held for exactly one taking edge.
    task automatic func(input logic [15:0] ctl, input logic [15:0] d, output logic e,
                        output logic [15:0] rd);
        @(negedge mclk);
        funcValid = 1'b1;
        funcReq = '{ctl: ctl, data: d};
        @(negedge mclk);
        funcValid = 1'b0;
        for (int i = 0; i < 4 && funcDone !== 1'b1; i++) @(negedge mclk);
        chk("funcDone", 16'h0001, {15'h0, funcDone});
        e = funcError;
        rd = funcRdata;
        @(negedge mclk);
    endtask : func

    // Mode write with expected error flag and resulting mode word.
    task automatic wr(input logic [15:0] d, input logic xe, input logic [15:0] xm);
        logic e;
        logic [15:0] rd;
        func({8'h00, OP_WRITE_MODE}, d, e, rd);
        chk("funcError", {15'h0, xe}, {15'h0, e});
        chk("modeWord", xm, modeWord);
    endtask : wr

    task automatic t_reset;
        chk("modeWord", MODE_RESET, modeWord);
        chk("sysIdEnable", 16'h0001, {15'h0, sysIdEnable});
        chk("loopMode", 16'h0000, {14'h0, loopMode});
        chk("loopMaxLen", 16'h0020, {8'h00, loopMaxLen});
        chk("counts", 16'h0000, driverErrCount | babbleCount);
        $display("test reset done");
    endtask : t_reset

    task automatic t_mode;
        logic e;
        logic [15:0] rd;
        wr(16'hF24D, 1'b0, 16'hF24C);
        func({8'h00, OP_READ_MODE}, 16'h1234, e, rd);
        chk("readData", 16'hF24C, rd);
        chk("modeWord", 16'hF24C, modeWord);
        chk("loopMode", {14'h0, LOOP_INTERNAL}, {14'h0, loopMode});
        chk("loopMaxLen", 16'h0024, {8'h00, loopMaxLen});
        chk("crcOff", 16'h0001, {15'h0, crcOff});
        wr(16'h0004, 1'b0, 16'h0004);
        chk("loopMode", {14'h0, LOOP_EXTERNAL}, {14'h0, loopMode});
        chk("loopMaxLen", 16'h0020, {8'h00, loopMaxLen});
        chk("maintSuppress", 16'h0001, {15'h0, maintSuppress});
        wr(16'h0200, 1'b0, 16'h0200);
        chk("sysIdEnable", 16'h0000, {15'h0, sysIdEnable});
        wr(16'h0040, 1'b1, 16'h0200);
        wr(16'h0000, 1'b0, 16'h0000);
        chk("loopMode", 16'h0000, {14'h0, loopMode});
        $display("test mode done");
    endtask : t_mode

    // Nonzero high byte, a foreign opcode and every reserved bit are refused.
    task automatic t_refuse;
        logic e;
        logic [15:0] rd;
        wr(16'h8000, 1'b0, 16'h8000);
        func({8'h01, OP_WRITE_MODE}, 16'h0000, e, rd);
        chk("funcError", 16'h0001, {15'h0, e});
        func(16'h0010, 16'h0000, e, rd);
        chk("funcError", 16'h0001, {15'h0, e});
        for (int i = 0; i < 16; i++)
            if (ZERO_REQUIRED_FIELD[i]) wr(16'h0001 << i, 1'b1, 16'h8000);
        $display("test refuse done");
    endtask : t_refuse

    // A second strobe while the first function runs is counted and ignored.
    task automatic t_drverr;
        logic [15:0] x;
        x = driverErrCount + 16'h0001;
        @(negedge mclk);
        funcValid = 1'b1;
        funcReq = '{ctl: {8'h00, OP_WRITE_MODE}, data: 16'h0000};
        @(negedge mclk);
        @(negedge mclk);
        funcValid = 1'b0;
        repeat (4) @(negedge mclk);
        chk("driverErrCount", x, driverErrCount);
        chk("modeWord", 16'h0000, modeWord);
        $display("test driver error done");
    endtask : t_drverr

    task automatic rx(input logic m, input logic mc, input logic ov, input logic xa,
                      input logic xt);
        far.frame(m, mc, ov);
        @(negedge mclk);
        chk("rxAccept", {15'h0, xa}, {15'h0, rxAccept});
        chk("rxTruncate", {15'h0, xt}, {15'h0, rxTruncate});
    endtask : rx

    task automatic t_rx;
        rx(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rx(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        wr(16'h2000, 1'b0, 16'h2000);
        rx(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        wr(16'h4000, 1'b0, 16'h4000);
        rx(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        rx(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(16'h8000, 1'b0, 16'h8000);
        rx(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        $display("test receive done");
    endtask : t_rx

    task automatic t_pad;
        wr(16'h1000, 1'b0, 16'h1000);
        for (int n = 0; n < 8; n++) begin
            far.setLen(11'(n));
            repeat (2) @(negedge mclk);
            chk("txPadBytes", (n < 6) ? 16'(6 - n) : 16'h0000, {13'h0, txPadBytes});
        end
        wr(16'h0000, 1'b0, 16'h0000);
        repeat (2) @(negedge mclk);
        chk("txPadBytes", 16'h0000, {13'h0, txPadBytes});
        $display("test pad done");
    endtask : t_pad

    // Interrupt on a rising error bit only while the enable is set.
    task automatic t_irq;
        logic seen;
        for (int k = 1; k >= 0; k--) begin
            wr(k ? 16'h0800 : 16'h0000, 1'b0, k ? 16'h0800 : 16'h0000);
            seen = 1'b0;
            far.setCte(1'b1);
            // An unknown pulse is carried into the flag so that the compare catches it.
            repeat (3) begin
                @(negedge mclk);
                seen = seen | collisionIrq;
            end
            chk("collisionIrq", 16'(k), {15'h0, seen});
            far.setCte(1'b0);
        end
        $display("test interrupt done");
    endtask : t_irq

    task automatic t_babble;
        int st;
        far.send(40, st);
        chk("babbleStop", 16'h0001, {15'h0, st >= 20 && st <= 22});
        repeat (2) @(negedge mclk);
        chk("txStop", 16'h0000, {15'h0, txStop});
        chk("babbleCount", 16'h0001, babbleCount);
        far.send(10, st);
        repeat (2) @(negedge mclk);
        chk("shortStop", 16'h0001, {15'h0, st == -1});
        chk("babbleCount", 16'h0001, babbleCount);
        $display("test babble done");
    endtask : t_babble

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Reset for 20 cycles, then the scenarios in turn.
    initial begin
        nrst = 1'b0;
        funcValid = 1'b0;
        funcReq = '0;
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        t_reset();
        t_mode();
        t_refuse();
        t_drverr();
        t_rx();
        t_pad();
        t_irq();
        t_babble();
        test_done();
    end
endmodule : testbench
